// ### dpo_pkg.sv
// Purpose: shared constants and types for the parallel video/audio output block
// Assumes: pixel clock domain is the link clock, mclk_i is the system clock
// Notes:   reg_driven_outputs bits are numbered 0..4 and drive the pins numbered 4..8
package dpo_pkg;
	localparam int unsigned COLOR_W         = 8;
	localparam int unsigned BUS_W           = 31;
	localparam int unsigned GPIO_N          = 4;
	localparam int unsigned GPO_N           = 5;
	localparam int unsigned FILT_MIN_PCLK   = 3;
	localparam int unsigned CTRL_WIN_PCLK   = 130;
	localparam int unsigned FIFO_DEPTH      = 16;
	localparam int unsigned MCLK_RATIO_X1   = 0;
	localparam int unsigned GPO_B0_IDX      = 0;
	localparam int unsigned GPO_B1_IDX      = 1;
	localparam int unsigned GPO_DA_IDX      = 2;
	localparam int unsigned GPO_WC_IDX      = 3;
	localparam int unsigned GPO_CK_IDX      = 4;
	localparam logic [1:0]  MCLK_SEL_RST    = 2'h0;
	localparam logic        LOCK_RST        = 1'b0;

	typedef enum logic [1:0] {
		DPO_MCLK_X1,
		DPO_MCLK_X2,
		DPO_MCLK_X4,
		DPO_MCLK_RSV
	} dpo_mclk_sel_t;

	typedef struct packed {
		logic [COLOR_W-1:0] red;
		logic [COLOR_W-1:0] green;
		logic [COLOR_W-1:0] blue;
		logic               hsync;
		logic               vsync;
		logic               de;
		logic               aclk;
		logic               awc;
		logic               ada;
	} dpo_word_t;
endpackage : dpo_pkg

// ### dpo_stream_if.sv
// Purpose: valid/ready word channel between the block's modules
// Assumes: one clock per side is supplied by the modules that use it
// Notes:   data is the full 30-bit output word
`timescale 1ns/1ps
interface dpo_stream_if;
	import dpo_pkg::*;
	logic      valid;
	logic      ready;
	dpo_word_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : dpo_stream_if

// ### dpo_fifo.sv
// Purpose: dual-clock FIFO with gray-coded pointers
// Assumes: DEPTH is a power of two
// Notes:   full and empty are conservative across the crossing
`timescale 1ns/1ps
module dpo_fifo #(
	parameter int unsigned WIDTH = 31,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             wclk_i,
	input  wire logic             wrst_i,
	input  wire logic             wvalid_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	output logic                  wready_o,
	input  wire logic             rclk_i,
	input  wire logic             rrst_i,
	output logic                  rvalid_o,
	output logic [WIDTH-1:0]      rdata_o,
	input  wire logic             rready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin_reg, wgray_reg, rbin_reg, rgray_reg;
	logic [AW:0]      rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
	logic [AW:0]      wbin_next, rbin_next;
	logic             wr_en, rd_en;

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction : bin2gray

	assign wready_o  = (wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]});
	assign rvalid_o  = (rgray_reg != wg_s2_reg);
	assign wr_en     = wvalid_i & wready_o;
	assign rd_en     = rvalid_o & rready_i;
	assign wbin_next = wbin_reg + (AW+1)'(wr_en);
	assign rbin_next = rbin_reg + (AW+1)'(rd_en);
	assign rdata_o   = mem[rbin_reg[AW-1:0]];

	always_ff @(posedge wclk_i) begin
		if (wr_en) begin
			mem[wbin_reg[AW-1:0]] <= wdata_i;
		end
		if (wrst_i) begin
			wbin_reg  <= '0;
			wgray_reg <= '0;
			rg_s1_reg <= '0;
			rg_s2_reg <= '0;
		end else begin
			wbin_reg  <= wbin_next;
			wgray_reg <= bin2gray(wbin_next);
			rg_s1_reg <= rgray_reg;
			rg_s2_reg <= rg_s1_reg;
		end
	end

	always_ff @(posedge rclk_i) begin
		if (rrst_i) begin
			rbin_reg  <= '0;
			rgray_reg <= '0;
			wg_s1_reg <= '0;
			wg_s2_reg <= '0;
		end else begin
			rbin_reg  <= rbin_next;
			rgray_reg <= bin2gray(rbin_next);
			wg_s1_reg <= wgray_reg;
			wg_s2_reg <= wg_s1_reg;
		end
	end
endmodule : dpo_fifo

// ### dpo_ctrl_filter.sv
// Purpose: drop control pulses shorter than the minimum width
// Assumes: runs on the pixel clock, one sample per pixel
// Notes:   filtered output lags the input by MIN cycles
`timescale 1ns/1ps
module dpo_ctrl_filter #(
	parameter int unsigned MIN = 3
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic en_i,
	input  wire logic d_i,
	output logic      q_o
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       cand;
		logic       q;
	} dpo_flt_st_t;
	dpo_flt_st_t st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		if (!en_i) begin
			st_next.q    = d_i;
			st_next.cand = d_i;
			st_next.cnt  = '0;
		end else if (d_i != st_reg.cand) begin
			st_next.cand = d_i;
			st_next.cnt  = 8'h01;
		end else if (st_reg.cnt < 8'(MIN)) begin
			st_next.cnt = st_reg.cnt + 8'h01;
		end
		if (en_i && st_next.cnt >= 8'(MIN)) begin
			st_next.q = st_next.cand;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	// bypass keeps hsync/de aligned with colour when filtering is off
	assign q_o = en_i ? st_reg.q : d_i;
endmodule : dpo_ctrl_filter

// ### dpo_out.sv
// Purpose: parallel video and audio output stage of a serial link receiver
// Assumes: recovered words arrive on mclk_i; pclk_i is the recovered pixel clock
// Notes:   pins are modelled as data plus output enable, no high impedance here
`timescale 1ns/1ps
module dpo_out
	import dpo_pkg::*;
#(
	parameter int unsigned DEPTH = dpo_pkg::FIFO_DEPTH
) (
	input  wire logic                           mclk_i,
	input  wire logic                           srst_i,
	input  wire logic                           pclk_i,
	input  wire logic                           rec_valid_i,
	input  wire dpo_pkg::dpo_word_t             rec_word_i,
	output logic                                rec_ready_o,
	input  wire logic                           rec_locked_i,
	input  wire logic                           power_down_n_i,
	input  wire logic                           filter_en_i,
	input  wire logic                           strobe_edge_sel_i,
	input  wire logic [1:0]                     mclk_sel_i,
	input  wire logic                           mode18_pin_i,
	input  wire logic                           mode18_cfg_i,
	input  wire logic [dpo_pkg::GPIO_N-1:0]     gpio_en_i,
	input  wire logic [dpo_pkg::GPIO_N-1:0]     gpio_dir_out_i,
	input  wire logic [dpo_pkg::GPIO_N-1:0]     gpio_level_i,
	output logic [dpo_pkg::GPIO_N-1:0]          gpio_in_o,
	input  wire logic [dpo_pkg::GPO_N-1:0]      gpo_en_i,
	input  wire logic [dpo_pkg::GPO_N-1:0]      reg_driven_outputs_i,
	input  wire logic [dpo_pkg::COLOR_W-1:0]    red_pin_i,
	input  wire logic [dpo_pkg::COLOR_W-1:0]    green_pin_i,
	output logic [dpo_pkg::COLOR_W-1:0]         red_o,
	output logic [dpo_pkg::COLOR_W-1:0]         red_oe_o,
	output logic [dpo_pkg::COLOR_W-1:0]         green_o,
	output logic [dpo_pkg::COLOR_W-1:0]         green_oe_o,
	output logic [dpo_pkg::COLOR_W-1:0]         blue_o,
	output logic                                hsync_out_o,
	output logic                                vsync_out_o,
	output logic                                pixel_valid_out_o,
	output logic                                audio_bit_clk_o,
	output logic                                audio_word_clk_o,
	output logic                                audio_serial_data_o,
	output logic                                audio_mclk_o,
	output logic                                pclk_o,
	output logic                                outputs_oe_o,
	output logic                                lock_o,
	output logic                                recovery_run_o
);
	import dpo_pkg::*;

	typedef struct packed {
		logic [2:0] lock_sync;
		logic [1:0] pdn_sync;
		logic [1:0] edge_sync;
		logic [1:0] filt_sync;
		logic [1:0] m18_sync;
		logic [1:0] msel_s1;
		logic [1:0] msel_s2;
		logic [GPIO_N-1:0] gin_s1;
		logic [GPIO_N-1:0] gin_s2;
		dpo_word_t  word;
		logic       word_ok;
		logic [1:0] mdiv;
		logic       aclk_d;
		logic       mclk;
	} dpo_pix_st_t;

	typedef struct packed {
		logic       pdn_s1;
		logic       pdn_s2;
		logic       lock_s1;
		logic       lock_s2;
	} dpo_sys_st_t;

	dpo_pix_st_t p_reg, p_next;
	dpo_sys_st_t s_reg, s_next;
	logic        prst_s1_reg, prst_reg;
	logic        pclk_q_reg;
	logic        run;
	logic        mode18;
	logic        hs_f, de_f;
	logic [COLOR_W-1:0] r_gp, g_gp, r_gpoe, g_gpoe;

	dpo_stream_if fifo_in ();
	dpo_stream_if fifo_out ();

	// reset into the pixel domain through two flops
	always_ff @(posedge pclk_i) begin
		prst_s1_reg <= srst_i;
		prst_reg    <= prst_s1_reg;
	end

	always_comb begin
		s_next         = s_reg;
		s_next.pdn_s1  = power_down_n_i;
		s_next.pdn_s2  = s_reg.pdn_s1;
		s_next.lock_s1 = p_reg.lock_sync[2];
		s_next.lock_s2 = s_reg.lock_s1;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign run            = s_reg.pdn_s2;
	assign recovery_run_o = run;
	assign lock_o         = s_reg.lock_s2 & run;

	assign fifo_in.valid = rec_valid_i & run;
	assign fifo_in.data  = rec_word_i;
	assign rec_ready_o   = fifo_in.ready & run;

	dpo_fifo #(
		.WIDTH ($bits(dpo_word_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.wclk_i   (mclk_i),
		.wrst_i   (srst_i),
		.wvalid_i (fifo_in.valid),
		.wdata_i  (fifo_in.data),
		.wready_o (fifo_in.ready),
		.rclk_i   (pclk_i),
		.rrst_i   (prst_reg),
		.rvalid_o (fifo_out.valid),
		.rdata_o  (fifo_out.data),
		.rready_i (fifo_out.ready)
	);

	// one word per pixel clock drains the buffer
	assign fifo_out.ready = p_reg.pdn_sync[1];

	assign mode18 = p_reg.m18_sync[1];

	always_comb begin
		p_next           = p_reg;
		p_next.lock_sync = {p_reg.lock_sync[1:0], rec_locked_i & power_down_n_i};
		p_next.pdn_sync  = {p_reg.pdn_sync[0], power_down_n_i};
		p_next.edge_sync = {p_reg.edge_sync[0], strobe_edge_sel_i};
		p_next.filt_sync = {p_reg.filt_sync[0], filter_en_i};
		p_next.m18_sync  = {p_reg.m18_sync[0], mode18_pin_i | mode18_cfg_i};
		p_next.msel_s1   = mclk_sel_i;
		p_next.msel_s2   = p_reg.msel_s1;
		p_next.gin_s1    = {green_pin_i[1:0], red_pin_i[1:0]};
		p_next.gin_s2    = p_reg.gin_s1;
		p_next.word_ok   = fifo_out.valid & fifo_out.ready;
		if (fifo_out.valid && fifo_out.ready) begin
			p_next.word = fifo_out.data;
		end
		// master clock: x4 toggles every pclk, x2 every 2nd, x1 follows bit clock
		p_next.aclk_d = p_reg.word.aclk;
		p_next.mdiv   = p_reg.mdiv + 2'h1;
		case (dpo_mclk_sel_t'(p_reg.msel_s2))
			DPO_MCLK_X4: p_next.mclk = ~p_reg.mclk;
			DPO_MCLK_X2: begin
				if (p_reg.mdiv[0]) begin
					p_next.mclk = ~p_reg.mclk;
				end
			end
			default: p_next.mclk = p_reg.word.aclk;
		endcase
		if (!p_reg.pdn_sync[1]) begin
			p_next.word = '0;
			p_next.mclk = 1'b0;
		end
	end

	always_ff @(posedge pclk_i) begin
		if (prst_reg) begin
			p_reg <= '0;
		end else begin
			p_reg <= p_next;
		end
	end

	dpo_ctrl_filter #(.MIN(FILT_MIN_PCLK)) u_hs_flt (
		.clk_i (pclk_i),
		.rst_i (prst_reg),
		.en_i  (p_reg.filt_sync[1]),
		.d_i   (p_reg.word.hsync),
		.q_o   (hs_f)
	);

	dpo_ctrl_filter #(.MIN(FILT_MIN_PCLK)) u_de_flt (
		.clk_i (pclk_i),
		.rst_i (prst_reg),
		.en_i  (p_reg.filt_sync[1]),
		.d_i   (p_reg.word.de),
		.q_o   (de_f)
	);

	// colour pin sharing: bits 0/1 of red and green become gpio in 18-bit mode
	always_comb begin
		r_gp   = p_reg.word.red;
		g_gp   = p_reg.word.green;
		r_gpoe = {COLOR_W{1'b1}};
		g_gpoe = {COLOR_W{1'b1}};
		for (int i = 0; i < 2; i++) begin
			if (mode18 && gpio_en_i[i]) begin
				r_gp[i]   = gpio_level_i[i];
				r_gpoe[i] = gpio_dir_out_i[i];
			end
			if (mode18 && gpio_en_i[i+2]) begin
				g_gp[i]   = gpio_level_i[i+2];
				g_gpoe[i] = gpio_dir_out_i[i+2];
			end
		end
	end

	// launch edge: sample registered word on the selected pixel clock edge
	logic [$bits(dpo_word_t)-1:0] launch_rise_reg, launch_fall_reg, launch_sel;
	logic [2*COLOR_W-1:0] oe_rise_reg;
	logic [$bits(dpo_word_t)-1:0] launch_word;
	assign launch_word = {r_gp, g_gp, p_reg.word.blue, hs_f, p_reg.word.vsync, de_f,
		p_reg.word.aclk, p_reg.word.awc, p_reg.word.ada};

	always_ff @(posedge pclk_i) begin
		if (prst_reg) begin
			launch_rise_reg <= '0;
			oe_rise_reg     <= '0;
		end else begin
			launch_rise_reg <= launch_word;
			oe_rise_reg     <= {r_gpoe, g_gpoe};
		end
	end

	always_ff @(negedge pclk_i) begin
		if (prst_reg) begin
			launch_fall_reg <= '0;
		end else begin
			launch_fall_reg <= launch_rise_reg;
		end
	end

	assign launch_sel = p_reg.edge_sync[1] ? launch_fall_reg : launch_rise_reg;

	always_comb begin
		{red_o, green_o, blue_o, hsync_out_o, vsync_out_o, pixel_valid_out_o,
			audio_bit_clk_o, audio_word_clk_o, audio_serial_data_o} = launch_sel;
		if (gpo_en_i[GPO_B0_IDX]) begin
			blue_o[0] = reg_driven_outputs_i[GPO_B0_IDX];
		end
		if (gpo_en_i[GPO_B1_IDX]) begin
			blue_o[1] = reg_driven_outputs_i[GPO_B1_IDX];
		end
		if (gpo_en_i[GPO_DA_IDX]) begin
			audio_serial_data_o = reg_driven_outputs_i[GPO_DA_IDX];
		end
		if (gpo_en_i[GPO_WC_IDX]) begin
			audio_word_clk_o = reg_driven_outputs_i[GPO_WC_IDX];
		end
		if (gpo_en_i[GPO_CK_IDX]) begin
			audio_bit_clk_o = reg_driven_outputs_i[GPO_CK_IDX];
		end
	end

	assign outputs_oe_o = p_reg.pdn_sync[1];
	assign red_oe_o     = oe_rise_reg[2*COLOR_W-1:COLOR_W] & {COLOR_W{p_reg.pdn_sync[1]}};
	assign green_oe_o   = oe_rise_reg[COLOR_W-1:0] & {COLOR_W{p_reg.pdn_sync[1]}};
	assign gpio_in_o    = p_reg.gin_s2;
	assign audio_mclk_o = p_reg.mclk;
	assign pclk_o       = pclk_i & p_reg.pdn_sync[1];

	AST_LOCK_NEEDS_RUN: assert property (@(posedge mclk_i) disable iff (srst_i)
		lock_o |-> run) else $error("lock high while powered down");
	AST_PDN_STOPS: assert property (@(posedge mclk_i) disable iff (srst_i)
		!run |-> !recovery_run_o && !rec_ready_o) else $error("recovery runs in power down");
	AST_PDN_TRIS: assert property (@(posedge pclk_i) disable iff (prst_reg)
		!p_reg.pdn_sync[1] |-> !outputs_oe_o && red_oe_o == '0) else $error("pins driven in pd");
	AST_GPO_B0: assert property (@(posedge pclk_i) disable iff (prst_reg)
		gpo_en_i[0] |-> blue_o[0] == reg_driven_outputs_i[0]) else $error("gpo4 level wrong");
	AST_GPO_CK: assert property (@(posedge pclk_i) disable iff (prst_reg)
		gpo_en_i[4] |-> audio_bit_clk_o == reg_driven_outputs_i[4]) else $error("gpo8 wrong");
	AST_GPIO_MODE: assert property (@(posedge pclk_i) disable iff (prst_reg)
		!mode18 |=> oe_rise_reg == '1) else $error("gpio active outside 18-bit");
	AST_NOFILT: assert property (@(posedge pclk_i) disable iff (prst_reg)
		(!p_reg.filt_sync[1]) [*2] |=> launch_rise_reg[5] == $past(p_reg.word.hsync))
		else $error("filter on");
	AST_X4: assert property (@(posedge pclk_i) disable iff (prst_reg)
		(p_reg.msel_s2 == 2'h2 && p_reg.pdn_sync[1]) [*2] |-> p_reg.mclk != $past(p_reg.mclk))
		else $error("mclk x4 not toggling");
endmodule : dpo_out

// ### dpo_panel_model.sv
// Purpose: panel side of the parallel bus, samples words and resolves shared pins
// Assumes: samples on the pclk_o edge opposite to the launch edge
// Notes:   undriven shared pins settle to their pull-down level
`timescale 1ns/1ps
module dpo_panel_model
	import dpo_pkg::*;
(
	input  wire logic               pclk_i,
	input  wire logic               edge_sel_i,
	input  wire logic               cap_en_i,
	input  wire dpo_pkg::dpo_word_t word_i,
	input  wire logic [7:0]         red_i,
	input  wire logic [7:0]         red_oe_i,
	input  wire logic [7:0]         green_i,
	input  wire logic [7:0]         green_oe_i,
	input  wire logic [3:0]         drv_en_i,
	input  wire logic [3:0]         drv_val_i,
	output logic [7:0]              red_pin_o,
	output logic [7:0]              green_pin_o,
	output int                      de_pulses_o,
	output int                      de_len_o
);
	dpo_word_t q[$];
	dpo_word_t last = '0;
	int        run  = 0;

	initial begin
		de_pulses_o = 0;
		de_len_o = 0;
	end

	// sample opposite the launch edge
	always @(pclk_i) begin
		if (pclk_i === edge_sel_i) begin
			if (cap_en_i && word_i !== last)
				q.push_back(word_i);
			last = word_i;
			if (word_i.de === 1'b1)
				run++;
			else if (run > 0) begin
				de_pulses_o++;
				de_len_o = run;
				run = 0;
			end
		end
	end

	// pull-down wins when neither side drives
	assign red_pin_o   = (red_i & red_oe_i) | (~red_oe_i & {6'h00, drv_en_i[1:0] & drv_val_i[1:0]});
	assign green_pin_o = (green_i & green_oe_i) | (~green_oe_i & {6'h00, drv_en_i[3:2] & drv_val_i[3:2]});
endmodule : dpo_panel_model

// ### dpo_out_tb_top.sv
// Purpose: self-checking bench for the parallel video/audio output block
// Assumes: pclk_i runs at 32 ns, stopped only to fill the buffer
// Notes:   sources keep the control transition limits in their stimulus
`timescale 1ns/1ps
module dpo_out_tb_top;
	import dpo_pkg::*;
	logic mclk_i = 0, srst_i = 1, pclk_i = 0, pclk_run = 1, cap_en = 0;
	logic rec_valid_i = 0, rec_locked_i = 0, power_down_n_i = 1, filter_en_i = 0;
	logic strobe_edge_sel_i = 0, mode18_pin_i = 0, mode18_cfg_i = 0;
	logic [1:0] mclk_sel_i = 2'h0;
	logic [3:0] gpio_en_i = 4'h0, gpio_dir_out_i = 4'h0, gpio_level_i = 4'h0, gpio_in_o;
	logic [3:0] drv_en = 4'h0, drv_val = 4'h0;
	logic [4:0] gpo_en_i = 5'h00, reg_driven_outputs_i = 5'h00;
	logic [7:0] red_pin_i, green_pin_i, red_o, red_oe_o, green_o, green_oe_o, blue_o;
	logic rec_ready_o, hsync_out_o, vsync_out_o, pixel_valid_out_o, audio_bit_clk_o;
	logic audio_word_clk_o, audio_serial_data_o, audio_mclk_o, pclk_o, outputs_oe_o;
	logic lock_o, recovery_run_o;
	dpo_word_t rec_word_i = '0, seen;
	int err_total = 0, checks = 0, mc = 0, bc = 0, de_pulses, de_len;

	initial forever #4 mclk_i = ~mclk_i;
	initial begin
		#5;
		forever begin
			#16;
			if (pclk_run || pclk_i) pclk_i = ~pclk_i;
		end
	end
	always @(posedge audio_mclk_o) mc++;
	always @(posedge audio_bit_clk_o) bc++;
	assign seen = {red_o, green_o, blue_o, hsync_out_o, vsync_out_o, pixel_valid_out_o,
		audio_bit_clk_o, audio_word_clk_o, audio_serial_data_o};

	dpo_out #(.DEPTH(16)) DUT (.mclk_i, .srst_i, .pclk_i, .rec_valid_i, .rec_word_i,
		.rec_ready_o, .rec_locked_i, .power_down_n_i, .filter_en_i, .strobe_edge_sel_i,
		.mclk_sel_i, .mode18_pin_i, .mode18_cfg_i, .gpio_en_i, .gpio_dir_out_i, .gpio_level_i,
		.gpio_in_o, .gpo_en_i, .reg_driven_outputs_i, .red_pin_i, .green_pin_i, .red_o,
		.red_oe_o, .green_o, .green_oe_o, .blue_o, .hsync_out_o, .vsync_out_o,
		.pixel_valid_out_o, .audio_bit_clk_o, .audio_word_clk_o, .audio_serial_data_o,
		.audio_mclk_o, .pclk_o, .outputs_oe_o, .lock_o, .recovery_run_o);
	dpo_panel_model PNL (.pclk_i(pclk_o), .edge_sel_i(strobe_edge_sel_i), .cap_en_i(cap_en),
		.word_i(seen), .red_i(red_o), .red_oe_i(red_oe_o), .green_i(green_o),
		.green_oe_i(green_oe_o), .drv_en_i(drv_en), .drv_val_i(drv_val), .red_pin_o(red_pin_i),
		.green_pin_o(green_pin_i), .de_pulses_o(de_pulses), .de_len_o(de_len));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : step

	function automatic dpo_word_t mk(input int r, input int g, input logic c, input int a);
		dpo_word_t w;
		w = {8'(r), 8'(g), 8'(r + 8'h50), c, 1'b0, c, 3'(a)};
		return w;
	endfunction : mk

	task automatic push(input dpo_word_t w);
		int n;
		logic rdy;
		n = 0;
		rec_word_i = w;
		rec_valid_i = 1'b1;
		do begin
			rdy = rec_ready_o;
			@(posedge mclk_i);
			n++;
		end while (rdy !== 1'b1 && n < 2000);
		#1;
		if (n >= 2000) chk(0, 1, "push stalled");
	endtask : push

	task automatic t_lock;
		int n;
		chk(lock_o, 1'b0, "lock before recovery");
		rec_locked_i = 1'b1;
		n = 0;
		while (lock_o !== 1'b1 && n < 60) begin
			step(1);
			n++;
		end
		chk(lock_o, 1'b1, "lock without training");
		chk({outputs_oe_o, recovery_run_o}, 2'h3, "active when locked");
		$display("done lock");
	endtask : t_lock

	task automatic t_fill(input logic sel);
		int n;
		logic rdy;
		strobe_edge_sel_i = sel;
		step(40);
		@(negedge pclk_i) pclk_run = 1'b0;
		step(8);
		PNL.q.delete();
		cap_en = 1'b1;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			rec_word_i = mk(n + 1 + 32 * sel, 8'hA0 + n, 1'b0, n);
			rec_valid_i = 1'b1;
			rdy = rec_ready_o;
			@(posedge mclk_i);
			if (rdy === 1'b1) n++;
			#1;
		end
		rec_valid_i = 1'b0;
		chk(n, 16, "buffer refuses when full");
		pclk_run = 1'b1;
		step(300);
		chk(PNL.q.size(), n, "words drained");
		for (int i = 0; i < PNL.q.size(); i++)
			chk(PNL.q[i], mk(i + 1 + 32 * sel, 8'hA0 + i, 1'b0, i), "word order");
		cap_en = 1'b0;
		$display("done fill edge %0d", sel);
	endtask : t_fill

	task automatic t_filter(input logic en);
		int p0;
		filter_en_i = en;
		step(20);
		p0 = de_pulses;
		// source keeps two control transitions per 130 pixels
		for (int i = 0; i < 300; i++)
			push(mk(0, 0, (i >= 10 && i < 12) || (i >= 152 && i < 157), 0));
		rec_valid_i = 1'b0;
		step(120);
		chk(de_pulses - p0, en ? 1 : 2, "control pulse count");
		chk(de_len, 5, "long pulse length");
		$display("done filter %0d", en);
	endtask : t_filter

	task automatic t_mclk;
		for (int s = 0; s < 3; s++) begin
			mclk_sel_i = 2'(s);
			step(20);
			for (int i = 0; i < 160; i++) begin
				if (i == 32) begin
					mc = 0;
					bc = 0;
				end
				push(mk(0, 0, 1'b0, 4 * i[2]));
			end
			rec_valid_i = 1'b0;
			chk(mc >= (bc << s) - 3 && mc <= (bc << s) + 3, 1, "master clock ratio");
			step(120);
		end
		$display("done mclk");
	endtask : t_mclk

	task automatic t_gpo;
		gpo_en_i = 5'h1F;
		for (int i = 0; i < 2; i++) begin
			reg_driven_outputs_i = i ? 5'h0A : 5'h15;
			step(3);
			chk({audio_bit_clk_o, audio_word_clk_o, audio_serial_data_o, blue_o[1:0]},
				reg_driven_outputs_i, "register driven outputs");
		end
		gpo_en_i = 5'h00;
		$display("done gpo");
	endtask : t_gpo

	task automatic t_gpio;
		gpio_en_i = 4'hF;
		gpio_dir_out_i = 4'hF;
		gpio_level_i = 4'h5;
		mode18_pin_i = 1'b1;
		step(40);
		chk({green_o[1:0], red_o[1:0]}, 4'h5, "gpio out by pin mode");
		mode18_pin_i = 1'b0;
		mode18_cfg_i = 1'b1;
		gpio_level_i = 4'hA;
		step(40);
		chk({green_o[1:0], red_o[1:0]}, 4'hA, "gpio out by config mode");
		gpio_dir_out_i = 4'h0;
		drv_en = 4'hF;
		drv_val = 4'h6;
		step(40);
		chk({green_oe_o[1:0], red_oe_o[1:0]}, 4'h0, "gpio input released");
		chk(gpio_in_o, 4'h6, "gpio input level");
		drv_en = 4'h0;
		gpio_dir_out_i = 4'hF;
		gpio_level_i = 4'hF;
		mode18_cfg_i = 1'b0;
		step(40);
		chk({green_o[1:0], red_o[1:0]}, 4'h0, "colour bits back in 24-bit");
		$display("done gpio");
	endtask : t_gpio

	task automatic t_pdown;
		power_down_n_i = 1'b0;
		step(40);
		chk({outputs_oe_o, red_oe_o, green_oe_o}, 17'h0, "outputs released");
		chk({recovery_run_o, rec_ready_o, lock_o}, 3'h0, "recovery stopped");
		power_down_n_i = 1'b1;
		step(80);
		chk({outputs_oe_o, lock_o, rec_ready_o}, 3'h7, "normal operation");
		$display("done power down");
	endtask : t_pdown

	task results;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	initial begin
		repeat (16) @(posedge mclk_i);
		#1 srst_i = 1'b0;
		step(20);
		t_lock();
		t_fill(1'b0);
		t_fill(1'b1);
		t_filter(1'b1);
		t_filter(1'b0);
		t_mclk();
		t_gpo();
		t_gpio();
		t_pdown();
		results();
	end

	initial begin
		#300000;
		err_total++;
		results();
	end
endmodule : dpo_out_tb_top
